/* File: hw/bois_datapath.sv */
// Functional notes
// - Jump loads 11-bit immediate, flags untouched
// - Jump fills PC<14:11> from page latch<6:3>
// - Jump takes two instruction cycles
// - OR literal into accumulator, update zero
// - Increment file register, route by destination
// - OR accumulator with file register, route
// - Left shift: bit7 to carry, zero in
// - Right shift: bit0 to carry, zero in
`timescale 1ns/10ps
`include "bois_defines.svh"

module bois_datapath
   import bois_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic exec_valid,
   input wire bois_req_type exec_req,
   output logic exec_ready,
   output logic [`BOIS_PC_W-1:0] pc_value,
   output logic [`BOIS_DATA_W-1:0] acc_value,
   output logic zero_flag,
   output logic carry_flag,
   output logic file_we,
   output logic [`BOIS_DATA_W-1:0] file_wdata,
   output logic retire,
   output logic fetch_flush
);

   bois_state_type state_reg;
   bois_state_type state_next;
   bois_alu_out_type alu_res;
   logic take;
   logic [`BOIS_PC_W-1:0] jump_target;
   logic result_is_zero;

   // Data result for the instruction being taken
   bois_alu u_alu (
      .req(exec_req),
      .acc(state_reg.acc),
      .res(alu_res)
   );

   // Request is taken only in the ready phase
   assign exec_ready = (state_reg.phase == BOIS_PH_READY);
   assign take = exec_valid & exec_ready;

   // Upper page bits joined with the immediate
   assign jump_target = {
      exec_req.pc_page_latch[`BOIS_PAGE_HI:`BOIS_PAGE_LO],
      exec_req.literal[`BOIS_LIT_MSB:0]
   };

   // Zero detect on the full 8-bit result
   assign result_is_zero = (alu_res.value == `BOIS_DATA_ZERO);

   // Next-state logic for the whole datapath
   always_comb begin
      state_next = state_reg;
      // Strobes last one cycle only
      state_next.file_we = 1'b0;
      state_next.retire = 1'b0;
      state_next.fetch_flush = 1'b0;
      case (state_reg.phase)
         BOIS_PH_READY: begin
            if (take) begin
               if (exec_req.op == BOIS_OP_JUMP_IMMEDIATE) begin
                  // Flags stay as they are on a jump
                  state_next.pc = jump_target;
                  state_next.fetch_flush = 1'b1;
                  state_next.phase = BOIS_PH_REFETCH;
               end else if (exec_req.op != BOIS_OP_IDLE) begin
                  state_next.pc = state_reg.pc + `BOIS_PC_STEP;
                  state_next.retire = 1'b1;
                  if (alu_res.acc_upd) begin
                     state_next.acc = alu_res.value;
                  end
                  if (alu_res.file_upd) begin
                     state_next.file_we = 1'b1;
                     state_next.file_wdata = alu_res.value;
                  end
                  if (alu_res.zero_upd) begin
                     state_next.zero = result_is_zero;
                  end
                  if (alu_res.carry_upd) begin
                     state_next.carry = alu_res.carry;
                  end
               end
            end
         end
         BOIS_PH_REFETCH: begin
            // Second jump cycle: the old fetch is discarded here
            state_next.phase = BOIS_PH_READY;
            state_next.retire = 1'b1;
         end
         default: begin
            state_next.phase = BOIS_PH_READY;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg.phase <= BOIS_PH_READY;
         state_reg.pc <= `BOIS_PC_RESET;
         state_reg.acc <= `BOIS_ACC_RESET;
         state_reg.zero <= 1'b0;
         state_reg.carry <= 1'b0;
         state_reg.file_we <= 1'b0;
         state_reg.file_wdata <= `BOIS_DATA_ZERO;
         state_reg.retire <= 1'b0;
         state_reg.fetch_flush <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state flops
   assign pc_value = state_reg.pc;
   assign acc_value = state_reg.acc;
   assign zero_flag = state_reg.zero;
   assign carry_flag = state_reg.carry;
   assign file_we = state_reg.file_we;
   assign file_wdata = state_reg.file_wdata;
   assign retire = state_reg.retire;
   assign fetch_flush = state_reg.fetch_flush;

endmodule // bois_datapath

/* File: hw/bois_defines.svh */
`ifndef BOIS_DEFINES_SVH
`define BOIS_DEFINES_SVH

// Datapath widths
`define BOIS_DATA_W 8
`define BOIS_DATA_MSB 7
`define BOIS_LIT_W 11
`define BOIS_LIT_MSB 10
`define BOIS_PC_W 15
`define BOIS_PAGE_W 7

// Page latch field that feeds the upper program counter bits
`define BOIS_PAGE_HI 6
`define BOIS_PAGE_LO 3

// Reset values and step constants
`define BOIS_PC_RESET 15'h0000
`define BOIS_PC_STEP 15'h0001
`define BOIS_ACC_RESET 8'h00
`define BOIS_DATA_ZERO 8'h00
`define BOIS_INC_STEP 8'h01

`endif

/* File: hw/bois_pkg.sv */
`include "bois_defines.svh"

package bois_pkg;

   // Operations this datapath executes
   typedef enum logic [2:0] {
      BOIS_OP_IDLE,
      BOIS_OP_JUMP_IMMEDIATE,
      BOIS_OP_OR_LITERAL_INTO_ACC,
      BOIS_OP_INCREMENT_FILE_REG,
      BOIS_OP_OR_ACC_WITH_FILE_REG,
      BOIS_OP_SHIFT_LEFT_LOGICAL,
      BOIS_OP_SHIFT_RIGHT_LOGICAL
   } bois_op_type;

   // One decoded instruction with its operands
   typedef struct packed {
      bois_op_type op;
      logic [`BOIS_LIT_W-1:0] literal;
      logic dest_file;
      logic [`BOIS_DATA_W-1:0] file_data;
      logic [`BOIS_PAGE_W-1:0] pc_page_latch;
   } bois_req_type;

   // Arithmetic unit answer
   typedef struct packed {
      logic [`BOIS_DATA_W-1:0] value;
      logic carry;
      logic carry_upd;
      logic zero_upd;
      logic acc_upd;
      logic file_upd;
   } bois_alu_out_type;

   typedef enum logic {
      BOIS_PH_READY,
      BOIS_PH_REFETCH
   } bois_phase_type;

   // All state of the datapath
   typedef struct packed {
      bois_phase_type phase;
      logic [`BOIS_PC_W-1:0] pc;
      logic [`BOIS_DATA_W-1:0] acc;
      logic zero;
      logic carry;
      logic file_we;
      logic [`BOIS_DATA_W-1:0] file_wdata;
      logic retire;
      logic fetch_flush;
   } bois_state_type;

endpackage

/* File: hw/bois_alu.sv */
`timescale 1ns/10ps
`include "bois_defines.svh"

module bois_alu
   import bois_pkg::*;
(
   input wire bois_req_type req,
   input wire logic [`BOIS_DATA_W-1:0] acc,
   output bois_alu_out_type res
);

   // Pure combinational result, routing and flag selection
   always_comb begin
      res = '0;
      case (req.op)
         BOIS_OP_OR_LITERAL_INTO_ACC: begin
            res.value = acc | req.literal[`BOIS_DATA_MSB:0];
            res.zero_upd = 1'b1;
            res.acc_upd = 1'b1;
         end
         BOIS_OP_INCREMENT_FILE_REG: begin
            // Wraps at the top; no carry out on increment
            res.value = req.file_data + `BOIS_INC_STEP;
            res.zero_upd = 1'b1;
            res.acc_upd = ~req.dest_file;
            res.file_upd = req.dest_file;
         end
         BOIS_OP_OR_ACC_WITH_FILE_REG: begin
            res.value = acc | req.file_data;
            res.zero_upd = 1'b1;
            res.acc_upd = ~req.dest_file;
            res.file_upd = req.dest_file;
         end
         BOIS_OP_SHIFT_LEFT_LOGICAL: begin
            res.value = {req.file_data[`BOIS_DATA_MSB-1:0], 1'b0};
            res.carry = req.file_data[`BOIS_DATA_MSB];
            res.carry_upd = 1'b1;
            res.zero_upd = 1'b1;
            res.acc_upd = ~req.dest_file;
            res.file_upd = req.dest_file;
         end
         BOIS_OP_SHIFT_RIGHT_LOGICAL: begin
            res.value = {1'b0, req.file_data[`BOIS_DATA_MSB:1]};
            res.carry = req.file_data[0];
            res.carry_upd = 1'b1;
            res.zero_upd = 1'b1;
            res.acc_upd = ~req.dest_file;
            res.file_upd = req.dest_file;
         end
         default: begin
            // Jump and idle produce no data result
            res = '0;
         end
      endcase
   end

endmodule // bois_alu

/* File: dv/bois_datapath_assertions.sv */
`timescale 1ns/10ps
`include "bois_defines.svh"

module bois_checker
   import bois_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic exec_valid,
   input wire bois_req_type exec_req,
   input wire logic exec_ready,
   input wire logic [`BOIS_PC_W-1:0] pc_value,
   input wire logic [`BOIS_DATA_W-1:0] acc_value,
   input wire logic zero_flag,
   input wire logic carry_flag,
   input wire logic file_we,
   input wire logic [`BOIS_DATA_W-1:0] file_wdata,
   input wire logic retire,
   input wire logic fetch_flush
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Taken requests by kind
   wire t = exec_valid && exec_ready;
   wire jmp = t && exec_req.op == BOIS_OP_JUMP_IMMEDIATE;
   wire orl = t && exec_req.op == BOIS_OP_OR_LITERAL_INTO_ACC;
   wire inc = t && exec_req.op == BOIS_OP_INCREMENT_FILE_REG;
   wire orf = t && exec_req.op == BOIS_OP_OR_ACC_WITH_FILE_REG;
   wire shl = t && exec_req.op == BOIS_OP_SHIFT_LEFT_LOGICAL;
   wire shr = t && exec_req.op == BOIS_OP_SHIFT_RIGHT_LOGICAL;
   // File writes let zero be judged on the written value
   wire tf = (inc || orf || shl || shr) && exec_req.dest_file;
   property p_jpc;
      jmp |=> pc_value == {$past(exec_req.pc_page_latch[6:3]),
                           $past(exec_req.literal)};
   endproperty
   a_jpc: assert property (p_jpc) else $error("jump pc");
   property p_jflg; jmp |=> $stable(zero_flag) && $stable(carry_flag);
   endproperty
   a_jflg: assert property (p_jflg) else $error("jump flags");
   property p_jcyc; jmp |=> fetch_flush && !exec_ready && !retire ##1 retire;
   endproperty
   a_jcyc: assert property (p_jcyc) else $error("jump cycles");
   property p_orl;
      orl |=> acc_value == ($past(acc_value) | $past(exec_req.literal[7:0]));
   endproperty
   a_orl: assert property (p_orl) else $error("or literal");
   property p_inc; inc && !exec_req.dest_file |=>
      acc_value == $past(exec_req.file_data) + 8'h01; endproperty
   a_inc: assert property (p_inc) else $error("increment");
   property p_orf; orf && exec_req.dest_file |=> file_we &&
      file_wdata == ($past(acc_value) | $past(exec_req.file_data));
   endproperty
   a_orf: assert property (p_orf) else $error("or file");
   property p_lsl; shl |=> carry_flag == $past(exec_req.file_data[7]);
   endproperty
   a_lsl: assert property (p_lsl) else $error("left carry");
   property p_lsr; shr |=> carry_flag == $past(exec_req.file_data[0]);
   endproperty
   a_lsr: assert property (p_lsr) else $error("right carry");
   property p_zf; tf |=> file_we && zero_flag == (file_wdata == 8'h00);
   endproperty
   a_zf: assert property (p_zf) else $error("zero flag");
   // Main scenarios
   c_jump: cover property (jmp ##2 retire);
   c_orf: cover property (orf && exec_req.dest_file);
   c_shr: cover property (shr ##1 carry_flag);
endmodule // bois_checker

bind bois_datapath bois_checker i_chk (.*);

/* File: dv/test_branch_or_inc_shift_datapath.sv */
`timescale 1ns/10ps

module test_branch_or_inc_shift_datapath
   import bois_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic exec_valid = 1'b0;
   bois_req_type exec_req = '0;
   logic exec_ready, zero_flag, carry_flag, file_we, retire, fetch_flush;
   logic [14:0] pc_value;
   logic [7:0] acc_value, file_wdata;
   int fails = 0;
   int cmp_count = 0;
   // 25 MHz clock
   always #20 clk = ~clk;
   bois_datapath i_dut (.clk, .rst_b, .exec_valid, .exec_req, .exec_ready,
      .pc_value, .acc_value, .zero_flag, .carry_flag, .file_we, .file_wdata,
      .retire, .fetch_flush);
   task chk(input string n, input logic [14:0] s, e);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task ck(input logic [7:0] a, fd, input logic z, c, w);
      chk("acc", acc_value, a);
      chk("fdata", file_wdata, fd);
      chk("zero", zero_flag, z);
      chk("carry", carry_flag, c);
      chk("we", file_we, w);
   endtask
   task results;
      if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Valid stays high between requests, so a refused one is simply held
   task go(input bois_op_type op, input logic [10:0] k, input logic d,
      input logic [7:0] f, input logic [6:0] pg = 7'h00);
      int n;
      n = 0;
      exec_req = '{op, k, d, f, pg};
      exec_valid = 1'b1;
      while (exec_ready !== 1'b1 && n < 9) begin
         @(posedge clk);
         #2;
         n++;
      end
      // A request that is never taken counts as a mismatch
      chk("ready", exec_ready, 1'b1);
      @(posedge clk);
      #2;
   endtask
   task t_jump;
      go(BOIS_OP_SHIFT_LEFT_LOGICAL, 11'h000, 1'b1, 8'h80);
      ck(8'h00, 8'h00, 1'b1, 1'b1, 1'b1);
      go(BOIS_OP_JUMP_IMMEDIATE, 11'h7FF, 1'b0, 8'h00, 7'h55);
      chk("pc", pc_value, 15'h57FF);
      chk("flush", fetch_flush, 1'b1);
      chk("ready", exec_ready, 1'b0);
      ck(8'h00, 8'h00, 1'b1, 1'b1, 1'b0);
      @(posedge clk);
      #2;
      chk("retire", retire, 1'b1);
      chk("pc", pc_value, 15'h57FF);
      go(BOIS_OP_OR_LITERAL_INTO_ACC, 11'h7A5, 1'b0, 8'h00);
      ck(8'hA5, 8'h00, 1'b0, 1'b1, 1'b0);
      chk("pc", pc_value, 15'h5800);
   endtask
   task t_inc;
      go(BOIS_OP_INCREMENT_FILE_REG, 11'h000, 1'b0, 8'hFF);
      ck(8'h00, 8'h00, 1'b1, 1'b1, 1'b0);
      chk("retire", retire, 1'b1);
      go(BOIS_OP_INCREMENT_FILE_REG, 11'h000, 1'b1, 8'h7F);
      ck(8'h00, 8'h80, 1'b0, 1'b1, 1'b1);
   endtask
   task t_ior;
      go(BOIS_OP_OR_ACC_WITH_FILE_REG, 11'h000, 1'b1, 8'h00);
      ck(8'h00, 8'h00, 1'b1, 1'b1, 1'b1);
      go(BOIS_OP_OR_LITERAL_INTO_ACC, 11'h03C, 1'b0, 8'h00);
      go(BOIS_OP_OR_ACC_WITH_FILE_REG, 11'h000, 1'b0, 8'hC1);
      ck(8'hFD, 8'h00, 1'b0, 1'b1, 1'b0);
   endtask
   task t_shift;
      go(BOIS_OP_SHIFT_LEFT_LOGICAL, 11'h000, 1'b0, 8'h41);
      ck(8'h82, 8'h00, 1'b0, 1'b0, 1'b0);
      go(BOIS_OP_SHIFT_RIGHT_LOGICAL, 11'h000, 1'b1, 8'h03);
      ck(8'h82, 8'h01, 1'b0, 1'b1, 1'b1);
      go(BOIS_OP_SHIFT_RIGHT_LOGICAL, 11'h000, 1'b0, 8'h01);
      ck(8'h00, 8'h01, 1'b1, 1'b1, 1'b0);
   endtask
   // Main sequence, then a reset in mid-run
   initial begin
      repeat (6) @(posedge clk);
      #2;
      rst_b = 1'b1;
      t_jump;
      t_inc;
      t_ior;
      t_shift;
      rst_b = 1'b0;
      exec_valid = 1'b0;
      #2;
      chk("pc", pc_value, 15'h0000);
      chk("ready", exec_ready, 1'b1);
      ck(8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
      // Release again; idle is taken but must leave everything alone
      repeat (2) @(posedge clk);
      #2;
      rst_b = 1'b1;
      go(BOIS_OP_IDLE, 11'h7FF, 1'b1, 8'hFF);
      chk("pc", pc_value, 15'h0000);
      chk("retire", retire, 1'b0);
      ck(8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
      go(BOIS_OP_OR_LITERAL_INTO_ACC, 11'h011, 1'b0, 8'h00);
      chk("pc", pc_value, 15'h0001);
      chk("retire", retire, 1'b1);
      ck(8'h11, 8'h00, 1'b0, 1'b0, 1'b0);
      results;
   end
   // Hang guard, far beyond the few dozen cycles needed
   initial begin
      #100000;
      fails++;
      results;
   end
endmodule // test_branch_or_inc_shift_datapath
